// ---- microcode_trap_priority_vectoring.sv ----
// trap grouping, break request and prioritised vector drive for the microsequencer
`timescale 1ns/1ps
`include "trap_vector_regs.svh"

module microcode_trap_priority_vectoring (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clkEn,
  input wire trap_vector_pkg::group_one_cond_t groupOneCond,
  input wire trap_vector_pkg::group_two_cond_t groupTwoCond,
  input wire trap_vector_pkg::group_three_cond_t groupThreeCond,
  input wire logic sequenceBreakTrap,
  input wire logic secondCyclePhase,
  output logic groupOnePending,
  output logic groupTwoPending,
  output logic groupThreePending,
  output logic breakRequest,
  output logic groupOneVectorEnable,
  output logic groupTwoVectorEnable,
  output logic groupThreeVectorEnable,
  output logic [`VEC_WIDTH-1:0] vectorLines,
  output logic vectorLinesValid
);

  // timing of the trap path, one line per sampling edge
  //   edge n     : raw conditions sampled; pending flags and break request
  //                show one cycle later, so the clock generator always sees
  //                them a cycle behind the condition that caused them
  //   edge n+k   : the clock generator answers with the trap signal, lined
  //                up with a second cycle phase; k is set by its own pacing
  //   edge n+k+1 : trap and phase marker are sampled high together here;
  //                one group enable and its vector are registered
  //   edge n+k+2 : enables drop again unless trap and phase still stand
  // priority is taken from the raw conditions, not from the registered
  // pending flags; this saves a cycle between break request and vector,
  // at the cost that a condition dropping right at the slot edge lets a
  // lower group drive instead, which is the intended fallback
  // with nothing pending in the slot, no enable and no vector are given
  // master clear shares code zero with idle lines; the address controller
  // must qualify the lines with the valid flag or with the enables
  // page used and write in page sit in group two below page fault, since
  // all three are paging traps taken by the same service path
  // codes 06 to 15 (octal) are spare and are never produced by any group
  // clock enable low freezes every flop, so a frozen slot keeps its vector
  // and a frozen idle block ignores conditions until the enable returns
  // reset clears every output; no pending condition survives it, and a
  // condition still standing is picked up on the first enabled edge
  // the enables are registered, so the vector lines never see two groups
  // driving even for part of a cycle; the price is one cycle of latency
  // the block holds no counters and no memory; all state is recomputed
  // on every enabled edge from the inputs sampled there

  // highest-priority condition inside a group picks that group's code
  function automatic logic [`VEC_WIDTH-1:0] oneVector(
    input trap_vector_pkg::group_one_cond_t c);
    if (c.protectViolation) begin
      oneVector = `VEC_PROTECT_VIOL;
    end else if (c.ringDown) begin
      oneVector = `VEC_RING_DOWN;
    end else begin
      oneVector = `VEC_IDLE;
    end
  endfunction

  // group two: page fault first, then the two paging traps
  function automatic logic [`VEC_WIDTH-1:0] twoVector(
    input trap_vector_pkg::group_two_cond_t c);
    if (c.pageFault) begin
      twoVector = `VEC_PAGE_FAULT;
    end else if (c.pageUsed) begin
      twoVector = `VEC_PAGE_USED;
    end else begin
      twoVector = `VEC_WRITE_IN_PAGE;
    end
  endfunction

  // group three: clear first, then panel, then macro interrupt
  function automatic logic [`VEC_WIDTH-1:0] threeVector(
    input trap_vector_pkg::group_three_cond_t c);
    if (c.masterClear) begin
      threeVector = `VEC_MASTER_CLEAR;
    end else if (c.panelInterrupt) begin
      threeVector = `VEC_PANEL_INT;
    end else begin
      threeVector = `VEC_MACRO_INT;
    end
  endfunction

  // group flags, priority select and the chosen group's code
  trap_vector_pkg::group_flags_t pend;
  trap_vector_pkg::group_sel_t sel;
  logic [`VEC_WIDTH-1:0] selVector;

  // next values, one per output flop
  logic next_groupOnePending;
  logic next_groupTwoPending;
  logic next_groupThreePending;
  logic next_breakRequest;
  logic next_groupOneVectorEnable;
  logic next_groupTwoVectorEnable;
  logic next_groupThreeVectorEnable;
  logic [`VEC_WIDTH-1:0] next_vectorLines;
  logic next_vectorLinesValid;

  // pending flags follow the raw conditions, never the enables
  always_comb begin
    pend.groupOne = |groupOneCond;
    pend.groupTwo = |groupTwoCond;
    pend.groupThree = |groupThreeCond;
  end

  // fixed priority; a single select makes overlapping enables impossible
  always_comb begin
    sel = trap_vector_pkg::GRP_NONE;
    selVector = `VEC_IDLE;
    if (pend.groupOne) begin
      sel = trap_vector_pkg::GRP_ONE;
      selVector = oneVector(groupOneCond);
    end else if (pend.groupTwo) begin
      sel = trap_vector_pkg::GRP_TWO;
      selVector = twoVector(groupTwoCond);
    end else if (pend.groupThree) begin
      sel = trap_vector_pkg::GRP_THREE;
      selVector = threeVector(groupThreeCond);
    end
  end

  // the drive slot: trap up and second phase sampled in the same cycle
  logic driveSlot;
  assign driveSlot = sequenceBreakTrap && secondCyclePhase;

  // pending flags and break request: next values
  always_comb begin
    next_groupOnePending = pend.groupOne;
    next_groupTwoPending = pend.groupTwo;
    next_groupThreePending = pend.groupThree;
    next_breakRequest = pend.groupOne | pend.groupTwo | pend.groupThree;
  end

  // pending registers run whether or not a trap slot is open
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      groupOnePending <= 1'b0;
      groupTwoPending <= 1'b0;
      groupThreePending <= 1'b0;
      breakRequest <= 1'b0;
    end else if (clkEn) begin
      groupOnePending <= next_groupOnePending;
      groupTwoPending <= next_groupTwoPending;
      groupThreePending <= next_groupThreePending;
      breakRequest <= next_breakRequest;
    end
  end

  // vector enables: next values, only inside the drive slot
  always_comb begin
    next_groupOneVectorEnable = 1'b0;
    next_groupTwoVectorEnable = 1'b0;
    next_groupThreeVectorEnable = 1'b0;
    if (driveSlot) begin
      case (sel)
        trap_vector_pkg::GRP_ONE: begin
          next_groupOneVectorEnable = 1'b1;
        end
        trap_vector_pkg::GRP_TWO: begin
          next_groupTwoVectorEnable = 1'b1;
        end
        trap_vector_pkg::GRP_THREE: begin
          next_groupThreeVectorEnable = 1'b1;
        end
        default: begin
          next_groupOneVectorEnable = 1'b0;
        end
      endcase
    end
  end

  // enable registers; a single select keeps them one-hot or clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      groupOneVectorEnable <= 1'b0;
      groupTwoVectorEnable <= 1'b0;
      groupThreeVectorEnable <= 1'b0;
    end else if (clkEn) begin
      groupOneVectorEnable <= next_groupOneVectorEnable;
      groupTwoVectorEnable <= next_groupTwoVectorEnable;
      groupThreeVectorEnable <= next_groupThreeVectorEnable;
    end
  end

  // vector lines and valid flag follow the same slot and select
  always_comb begin
    next_vectorLines = `VEC_IDLE;
    next_vectorLinesValid = 1'b0;
    if (driveSlot && (sel != trap_vector_pkg::GRP_NONE)) begin
      next_vectorLines = selVector;
      next_vectorLinesValid = 1'b1;
    end
  end

  // vector registers; idle code with valid low outside the slot
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      vectorLines <= `VEC_IDLE;
      vectorLinesValid <= 1'b0;
    end else if (clkEn) begin
      vectorLines <= next_vectorLines;
      vectorLinesValid <= next_vectorLinesValid;
    end
  end

endmodule // microcode_trap_priority_vectoring

// ---- trap_vector_regs.svh ----
// trap vector codes, idle code and vector field width
`ifndef TRAP_VECTOR_REGS_SVH
`define TRAP_VECTOR_REGS_SVH
`define VEC_WIDTH 4
`define VEC_MASTER_CLEAR 4'h0
`define VEC_PAGE_FAULT 4'h1
`define VEC_PROTECT_VIOL 4'h2
`define VEC_RING_DOWN 4'h3
`define VEC_PAGE_USED 4'h4
`define VEC_WRITE_IN_PAGE 4'h5
`define VEC_PANEL_INT 4'he
`define VEC_MACRO_INT 4'hf
`define VEC_IDLE 4'h0
`endif

// ---- trap_vector_pkg.sv ----
// types shared by the trap priority logic
package trap_vector_pkg;
  typedef enum logic [1:0] {
    GRP_NONE,
    GRP_ONE,
    GRP_TWO,
    GRP_THREE
  } group_sel_t;

  typedef struct packed {
    logic protectViolation;
    logic ringDown;
  } group_one_cond_t;

  typedef struct packed {
    logic pageFault;
    logic pageUsed;
    logic writeInPage;
  } group_two_cond_t;

  typedef struct packed {
    logic masterClear;
    logic panelInterrupt;
    logic macroInterrupt;
  } group_three_cond_t;

  typedef struct packed {
    logic groupOne;
    logic groupTwo;
    logic groupThree;
  } group_flags_t;
endpackage

// ---- trap_prio_monitor.sv ----
// assertion checker bound to the trap priority block
`timescale 1ns/1ps
module trap_prio_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clkEn,
  input wire trap_vector_pkg::group_one_cond_t groupOneCond,
  input wire trap_vector_pkg::group_two_cond_t groupTwoCond,
  input wire trap_vector_pkg::group_three_cond_t groupThreeCond,
  input wire logic sequenceBreakTrap,
  input wire logic secondCyclePhase,
  input wire logic groupOnePending,
  input wire logic groupTwoPending,
  input wire logic breakRequest,
  input wire logic groupOneVectorEnable,
  input wire logic groupTwoVectorEnable,
  input wire logic groupThreeVectorEnable,
  input wire logic vectorLinesValid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // a slot opens only when trap and second phase are sampled together
  wire fire = clkEn && sequenceBreakTrap && secondCyclePhase;
  wire g1 = |groupOneCond;
  wire g2 = |groupTwoCond;
  a_one_pend:
    assert property (clkEn |=> groupOnePending == $past(g1)) else $error("g1 pending");
  a_two_pend:
    assert property (clkEn |=> groupTwoPending == $past(g2)) else $error("g2 pending");
  a_break_any:
    assert property (clkEn |=> breakRequest == $past(g1 || g2 || |groupThreeCond))
      else $error("break request");
  a_first_vec:
    assert property (fire && g1 |=> groupOneVectorEnable && vectorLinesValid) else $error("g1");
  a_second_vec:
    assert property (fire && !g1 && g2 |=> groupTwoVectorEnable) else $error("g2");
  a_third_vec:
    assert property (fire && !g1 && !g2 && |groupThreeCond |=> groupThreeVectorEnable)
      else $error("g3");
  a_single_drive:
    assert property ($onehot0({groupOneVectorEnable, groupTwoVectorEnable,
      groupThreeVectorEnable})) else $error("two drivers");
  a_no_slot:
    assert property (clkEn && !fire |=> !vectorLinesValid) else $error("vector outside slot");
endmodule // trap_prio_monitor
bind microcode_trap_priority_vectoring trap_prio_monitor i_mon (.*);

// ---- trap_clock_model.sv ----
// far side model: clock generation and microinstruction address controller
`timescale 1ns/1ps
module trap_clock_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic stall,
  input wire logic breakRequest,
  input wire logic vectorLinesValid,
  input wire logic [3:0] vectorLines,
  output logic sequenceBreakTrap,
  output logic secondCyclePhase,
  output logic [3:0] nextAddr
);
  // trap lands only on a second phase; stall plays a slow generator
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {sequenceBreakTrap, secondCyclePhase, nextAddr} <= 6'h00;
    end else begin
      secondCyclePhase <= !secondCyclePhase;
      sequenceBreakTrap <= breakRequest && !secondCyclePhase && !stall;
      nextAddr <= vectorLinesValid ? vectorLines : nextAddr + 4'h1;
    end
  end
endmodule // trap_clock_model

// ---- microcode_trap_priority_vectoring_tb.sv ----
// self-checking bench for the trap priority block
`timescale 1ns/1ps
module microcode_trap_priority_vectoring_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic stall = 1'b0;
  logic clkEn = 1'b1;
  logic [7:0] cond = 8'h00;
  logic groupOnePending, groupTwoPending, groupThreePending, breakRequest, vectorLinesValid;
  logic groupOneVectorEnable, groupTwoVectorEnable, groupThreeVectorEnable;
  logic sequenceBreakTrap, secondCyclePhase;
  logic [3:0] vectorLines, nextAddr;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #25 mclk = ~mclk;
  microcode_trap_priority_vectoring i_dut (.groupOneCond(cond[7:6]),
    .groupTwoCond(cond[5:3]), .groupThreeCond(cond[2:0]), .*);
  trap_clock_model i_far (.*);
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // highest set bit wins: {0, enables one-hot, vector}
  function automatic logic [7:0] expect_of(input logic [7:0] c);
    logic [3:0] codes [8] = '{4'hf, 4'he, 4'h0, 4'h5, 4'h4, 4'h1, 4'h3, 4'h2};
    expect_of = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (c[i]) expect_of = {1'b0, i > 5, i > 2 && i < 6, i < 3, codes[i]};
    end
  endfunction
  // hold conditions until a vector shows, compare, then release
  task automatic drive(input logic [7:0] c);
    int n;
    n = 0;
    @(posedge mclk) #2 cond = c;
    while (vectorLinesValid !== 1'b1 && n < 8) begin
      @(posedge mclk) #2 n++;
    end
    check("vector", {groupOneVectorEnable, groupTwoVectorEnable, groupThreeVectorEnable,
      vectorLines}, expect_of(c));
    check("pending", {groupOnePending, groupTwoPending, groupThreePending, breakRequest},
      {|c[7:6], |c[5:3], |c[2:0], 1'b1});
    @(posedge mclk) #2 cond = 8'h00;
    check("next address", nextAddr, expect_of(c) & 8'h0f);
    repeat (3) @(posedge mclk);
    #2 check("idle", vectorLinesValid, 8'h00);
  endtask
  task automatic test_codes();
    for (int i = 0; i < 8; i++) begin
      drive(8'h01 << i);
    end
    $display("test_codes done");
  endtask
  task automatic test_priority();
    logic [7:0] combos [7] = '{8'hc0, 8'h38, 8'h07, 8'hff, 8'h1f, 8'h03, 8'h5f};
    foreach (combos[i]) begin
      drive(combos[i]);
    end
    $display("test_priority done");
  endtask
  // slow clock generator: request stands, no vector until trap comes
  task automatic test_stall();
    @(posedge mclk) #2 stall = 1'b1;
    cond = 8'h20;
    repeat (6) @(posedge mclk);
    #2 check("held off", {breakRequest, vectorLinesValid}, 8'h02);
    stall = 1'b0;
    drive(8'h20);
    $display("test_stall done");
  endtask
  // clock enable low: nothing moves while a condition appears underneath
  task automatic test_freeze();
    @(posedge mclk) #2 clkEn = 1'b0;
    cond = 8'h80;
    repeat (3) @(posedge mclk);
    #2 check("frozen", {groupOnePending, breakRequest, vectorLinesValid}, 8'h00);
    clkEn = 1'b1;
    @(posedge mclk) #2 check("thawed", {groupOnePending, breakRequest}, 8'h03);
    drive(8'h80);
    $display("test_freeze done");
  endtask
  // reset in mid-run with a condition standing: outputs clear, then reload
  task automatic test_reset();
    @(posedge mclk) #2 cond = 8'h04;
    repeat (2) @(posedge mclk);
    #2 rst = 1'b1;
    #1 check("in reset", {groupThreePending, breakRequest, vectorLinesValid}, 8'h00);
    repeat (2) @(posedge mclk);
    #2 rst = 1'b0;
    @(posedge mclk) #2 check("after reset", {groupThreePending, breakRequest}, 8'h03);
    drive(8'h04);
    $display("test_reset done");
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // hang guard: the run needs under two hundred cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 1000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    repeat (12) @(posedge mclk);
    #2 rst = 1'b0;
    test_codes();
    test_priority();
    test_stall();
    test_freeze();
    test_reset();
    results();
  end
endmodule // microcode_trap_priority_vectoring_tb
